// File: sac_afe_model.sv
// Behavioural analog front end: sample-and-hold and comparator.
`timescale 1ns/10ps
module sac_afe_model (
  // Clock
  input wire logic clk,
  // Analog level of the selected input
  input wire logic [9:0] level,
  // Converter side
  input wire logic sample_en,
  input wire logic sar_power_on,
  input wire logic [sac_pkg::RES_W-1:0] dac_code,
  output logic cmp_above
);
  import sac_pkg::*;
  logic [RES_W-1:0] held = '0;
  logic churn = 1'b0;
  always @(posedge clk) begin
    churn <= ~churn;
    if (sample_en) begin
      held <= level;
    end
  end
  // A powered-down comparator gives no useful answer, so it churns rather than hold a level.
  assign cmp_above = sar_power_on ? (held >= dac_code) : churn;
endmodule

// File: sac_clk_if.sv
// Interface between the sequencer and the conversion clock generator.
`timescale 1ns/10ps
interface sac_clk_if;
  import sac_pkg::*;
  sac_src_t src;
  logic [1:0] div;
  logic run;
  logic tick;
  modport ctrl (output src, output div, output run, input tick);
  modport gen (input src, input div, input run, output tick);
endinterface

// File: sac_clkgen.sv
// Conversion clock source selection and divider.
`timescale 1ns/10ps
module sac_clkgen (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Clock sources
  input wire logic local_async_conv_clock,
  input wire logic external_reference_clock,
  // Power mode
  input wire logic deep_stop_mode,
  // Sequencer side
  sac_clk_if.gen ctl
);
  import sac_pkg::*;

  logic half_phase;
  logic async_q;
  logic alt_q;
  logic [DIV_CNT_W-1:0] div_cnt;
  logic bus_ok;
  logic async_edge;
  logic alt_edge;
  logic src_edge;
  logic [DIV_CNT_W-1:0] div_last;
  logic div_wrap;

  // ****************************************
  // Source edges
  // ****************************************
  // Bus-derived sources stop in deep stop; the local clock keeps running.
  assign bus_ok = ~deep_stop_mode; // [RULE16]
  assign async_edge = local_async_conv_clock & ~async_q;
  // Wait mode does not gate the alternate source, only deep stop does.
  assign alt_edge = external_reference_clock & ~alt_q & ~deep_stop_mode; // [RULE2] [RULE4]
  assign src_edge = (ctl.src == SAC_SRC_BUS) ? bus_ok :
                    (ctl.src == SAC_SRC_HALF) ? (bus_ok & half_phase) :
                    (ctl.src == SAC_SRC_ALT) ? alt_edge : async_edge; // [RULE1]

  // ****************************************
  // Divider
  // ****************************************
  assign div_last = DIV_CNT_W'((4'h1 << ctl.div) - 4'h1); // [RULE3]
  assign div_wrap = (div_cnt == div_last);
  assign ctl.tick = ctl.run & src_edge & div_wrap; // [RULE3]

  always_ff @(posedge clk) begin
    if (srst) begin
      half_phase <= 1'b0;
      async_q <= 1'b0;
      alt_q <= 1'b0;
    end else begin
      half_phase <= ~half_phase;
      async_q <= local_async_conv_clock;
      alt_q <= external_reference_clock;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !ctl.run) begin
      div_cnt <= '0;
    end else if (src_edge) begin
      div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
    end
  end

endmodule

// File: sac_ctrl.sv
// Successive-approximation converter control: registers, sequencer, result logic.
//
// Contract
// [RULE1] Conversion clock from one of four sources.
// [RULE2] Alternate source is the external reference clock.
// [RULE3] Selected source divided by programmed ratio.
// [RULE4] Alternate source keeps running in wait.
// [RULE5] Software avoids alternate source in deep stop.
// [RULE6] Software picks local clock before stop.
// [RULE7] Software keeps regulator on in stop.
// [RULE8] Temperature on channel 26, bandgap 27.
// [RULE9] Temperature needs long sample, slow clock.
// [RULE10] Linear ten-bit successive approximation.
// [RULE11] Right-justified ten- or eight-bit results.
// [RULE12] Single or continuous; single returns idle.
// [RULE13] Completion flag with interrupt request.
// [RULE14] Optional less-than or greater-equal compare.
// [RULE15] Channel select addresses up to 28 inputs.
// [RULE16] Conversions continue in wait and deep stop; here deep stop halts all sources but the local clock.
// [RULE17] All-ones channel turns converter off.
// [RULE18] Control write aborts and restarts conversion.
// [RULE19] Flag cleared by write or low read.
// [RULE20] Active set on start, cleared at end.
// [RULE21] Result updates only when flag sets.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module sac_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [sac_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sac_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sac_pkg::DATA_W-1:0] reg_rdata,
  // Clock sources and power mode
  input wire logic local_async_conv_clock,
  input wire logic external_reference_clock,
  input wire logic deep_stop_mode,
  // Analog front end
  input wire logic cmp_above,
  output logic [4:0] channel_select,
  output logic mux_isolate,
  output logic temp_sensor_en,
  output logic bandgap_en,
  output logic sar_power_on,
  output logic sample_en,
  output logic [sac_pkg::RES_W-1:0] dac_code,
  // Interrupt
  output logic irq
);
  import sac_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  sac_clk_if clk_bus ();

  sac_state_t state;
  sac_state_t next_state;
  logic conversion_done_flag;
  logic irq_en;
  logic cont_en;
  logic [4:0] ch;
  logic cmp_en;
  logic cmp_ge;
  logic [RES_W-1:0] cmp_val;
  logic [DATA_W-1:0] cfg;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] sar;
  logic [RES_W-1:0] trial;
  logic [4:0] smp_cnt;

  logic wr_sc1;
  logic wr_sc2;
  logic wr_cmp_hi;
  logic wr_cmp_lo;
  logic wr_cfg;
  logic rd_res_lo;
  logic wr_ch_off;
  logic [4:0] next_ch;
  logic start_req;
  logic stop_req;
  logic tick;
  logic conversion_active;
  logic [4:0] sample_last;
  logic sample_end;
  logic convert_end;
  logic done_evt;
  logic [RES_W-1:0] sar_keep;
  logic [RES_W-1:0] next_sar;
  logic [RES_W-1:0] fmt_val;
  logic mode_8bit;
  logic cmp_true;
  logic set_done;
  logic clr_done;
  logic [DATA_W-1:0] sc1_val;
  logic [DATA_W-1:0] sc2_val;
  logic [DATA_W-1:0] rd_mux;

  // ****************************************
  // Register decode
  // ****************************************
  assign wr_sc1 = reg_wr & (reg_addr == OFS_SC1);
  assign wr_sc2 = reg_wr & (reg_addr == OFS_SC2);
  assign wr_cmp_hi = reg_wr & (reg_addr == OFS_CMP_HI);
  assign wr_cmp_lo = reg_wr & (reg_addr == OFS_CMP_LO);
  assign wr_cfg = reg_wr & (reg_addr == OFS_CFG);
  assign rd_res_lo = reg_rd & (reg_addr == OFS_RES_LO);
  assign wr_ch_off = (reg_wdata[4:0] == CH_OFF);
  // The mux follows a write at once, so sampling never starts on the old channel.
  assign next_ch = wr_sc1 ? reg_wdata[4:0] : ch; // [RULE15]

  // A control write always ends the running conversion first.
  assign start_req = wr_sc1 & ~wr_ch_off; // [RULE18]
  assign stop_req = wr_sc1 & wr_ch_off; // [RULE17]

  // ****************************************
  // Clock generator
  // ****************************************
  assign clk_bus.src = sac_src_t'(cfg[CFG_SRC_LSB +: 2]); // [RULE1]
  assign clk_bus.div = cfg[CFG_DIV_LSB +: 2]; // [RULE3]
  // The divider is held clear while idle and on a restart, so every conversion
  // starts on a fresh divided period.
  assign clk_bus.run = ((state == SAC_SAMPLE) | (state == SAC_CONVERT)) & ~start_req; // [RULE18]
  assign tick = clk_bus.tick;

  sac_clkgen u_clkgen (
    .clk(clk),
    .srst(srst),
    .local_async_conv_clock(local_async_conv_clock),
    .external_reference_clock(external_reference_clock),
    .deep_stop_mode(deep_stop_mode),
    .ctl(clk_bus)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  assign sample_last = cfg[CFG_LONG] ? LONG_SAMPLE_TICKS : SHORT_SAMPLE_TICKS;
  assign sample_end = tick & (smp_cnt == sample_last - 5'h01);
  assign convert_end = tick & trial[0];
  assign done_evt = (state == SAC_DONE) & ~wr_sc1;
  assign conversion_active = (state != SAC_IDLE); // [RULE20]

  always_comb begin
    next_state = state;
    unique case (state)
      SAC_IDLE: begin
        if (start_req) begin
          next_state = SAC_SAMPLE; // [RULE20]
        end
      end
      SAC_SAMPLE: begin
        if (sample_end) begin
          next_state = SAC_CONVERT;
        end
      end
      SAC_CONVERT: begin
        if (convert_end) begin
          next_state = SAC_DONE;
        end
      end
      SAC_DONE: begin
        next_state = cont_en ? SAC_SAMPLE : SAC_IDLE; // [RULE12]
      end
    endcase
    if (start_req) begin
      next_state = SAC_SAMPLE; // [RULE18]
    end else if (stop_req) begin
      next_state = SAC_IDLE; // [RULE17]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= SAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || start_req || next_state != SAC_SAMPLE || state != SAC_SAMPLE) begin // [RULE18]
      smp_cnt <= 5'h00;
    end else if (tick) begin
      smp_cnt <= smp_cnt + 5'h01;
    end
  end

  // ****************************************
  // Successive approximation
  // ****************************************
  // One bit is decided per divided tick, most significant first; the trial
  // bit is dropped when the held input lies below the DAC level.
  assign sar_keep = cmp_above ? sar : (sar & ~trial); // [RULE10]
  assign next_sar = sar_keep | (trial >> 1);

  always_ff @(posedge clk) begin
    if (srst) begin
      sar <= '0;
      trial <= '0;
    end else if (state == SAC_SAMPLE && sample_end) begin
      sar <= RES_W'(1) << (RES_W - 1); // [RULE10]
      trial <= RES_W'(1) << (RES_W - 1);
    end else if (state == SAC_CONVERT && tick) begin
      sar <= next_sar; // [RULE10]
      trial <= trial >> 1;
    end
  end

  // ****************************************
  // Result format and compare
  // ****************************************
  assign mode_8bit = (cfg[CFG_MODE_LSB +: 2] == MODE_8BIT);
  assign fmt_val = mode_8bit ? {2'b00, sar[RES_W-1:2]} : sar; // [RULE11]
  assign cmp_true = cmp_ge ? (fmt_val >= cmp_val) : (fmt_val < cmp_val); // [RULE14]
  assign set_done = done_evt & (~cmp_en | cmp_true); // [RULE14] [RULE19]
  assign clr_done = wr_sc1 | rd_res_lo; // [RULE19]

  always_ff @(posedge clk) begin
    if (srst) begin
      result <= RES_RST;
    end else if (set_done) begin
      result <= fmt_val; // [RULE21]
    end
  end

  // A completion landing in the same cycle as a low result read is kept.
  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_done_flag <= 1'b0;
    end else begin
      conversion_done_flag <= set_done | (conversion_done_flag & ~clr_done); // [RULE13]
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_en <= 1'b0;
      cont_en <= 1'b0;
      ch <= CH_RST;
    end else if (wr_sc1) begin
      irq_en <= reg_wdata[SC1_IEN];
      cont_en <= reg_wdata[SC1_CONT];
      ch <= reg_wdata[4:0]; // [RULE15]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_en <= 1'b0;
      cmp_ge <= 1'b0;
    end else if (wr_sc2) begin
      cmp_en <= reg_wdata[SC2_CMP_EN];
      cmp_ge <= reg_wdata[SC2_CMP_GE];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_val <= CMP_RST;
    end else if (wr_cmp_hi) begin
      cmp_val[RES_W-1:8] <= reg_wdata[1:0];
    end else if (wr_cmp_lo) begin
      cmp_val[7:0] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= CFG_RST;
    end else if (wr_cfg) begin
      cfg <= reg_wdata;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  assign sc1_val = {conversion_done_flag, irq_en, cont_en, ch};
  assign sc2_val = {conversion_active, 1'b0, cmp_en, cmp_ge, 4'h0}; // [RULE20]
  assign rd_mux = (reg_addr == OFS_SC1) ? sc1_val :
                  (reg_addr == OFS_SC2) ? sc2_val :
                  (reg_addr == OFS_RES_HI) ? {6'h00, result[RES_W-1:8]} :
                  (reg_addr == OFS_RES_LO) ? result[7:0] :
                  (reg_addr == OFS_CMP_HI) ? {6'h00, cmp_val[RES_W-1:8]} :
                  (reg_addr == OFS_CMP_LO) ? cmp_val[7:0] :
                  (reg_addr == OFS_CFG) ? cfg : 8'h00; // [RULE11]

  // Read data is shown only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // Analog front end controls
  // ****************************************
  // Reserved channel codes are passed through and convert to an
  // undefined level in the analog mux.
  always_ff @(posedge clk) begin
    if (srst) begin
      channel_select <= CH_RST;
      mux_isolate <= 1'b1;
      temp_sensor_en <= 1'b0;
      bandgap_en <= 1'b0;
    end else begin
      channel_select <= next_ch; // [RULE15]
      mux_isolate <= (next_ch == CH_OFF); // [RULE17]
      temp_sensor_en <= (next_ch == CH_TEMP); // [RULE8]
      bandgap_en <= (next_ch == CH_BANDGAP); // [RULE8]
    end
  end

  // The analog core powers down by itself once a single conversion ends.
  always_ff @(posedge clk) begin
    if (srst) begin
      sar_power_on <= 1'b0;
      sample_en <= 1'b0;
      dac_code <= '0;
    end else begin
      sar_power_on <= (next_state != SAC_IDLE); // [RULE17] [RULE12]
      sample_en <= (next_state == SAC_SAMPLE);
      dac_code <= (state == SAC_SAMPLE && sample_end) ? (RES_W'(1) << (RES_W - 1)) :
                  (state == SAC_CONVERT && tick) ? next_sar : dac_code;
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_en & (set_done | (conversion_done_flag & ~clr_done)); // [RULE13] [RULE14]
    end
  end

endmodule

// File: sac_ctrl_checker.sv
// Port assertions for the converter control block.
`timescale 1ns/10ps
module sac_ctrl_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [sac_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sac_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Analog side and interrupt
  input wire logic [4:0] channel_select,
  input wire logic mux_isolate,
  input wire logic temp_sensor_en,
  input wire logic bandgap_en,
  input wire logic sar_power_on,
  input wire logic sample_en,
  input wire logic irq
);
  import sac_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  wire sc1_wr = reg_wr && reg_addr == OFS_SC1;
  wire lo_rd = reg_rd && reg_addr == OFS_RES_LO;
  property p_off;
    sc1_wr && reg_wdata[4:0] == CH_OFF |=> mux_isolate && !sar_power_on;
  endproperty
  a_off: assert property (p_off) else $error("converter runs after off write");
  property p_start;
    sc1_wr && reg_wdata[4:0] != CH_OFF |-> ##[1:2] sample_en && sar_power_on;
  endproperty
  a_start: assert property (p_start) else $error("no sampling after start");
  property p_clr;
    sc1_wr |=> !irq;
  endproperty
  a_clr: assert property (p_clr) else $error("flag kept after control write");
  property p_lo;
    lo_rd && !sar_power_on |=> !irq;
  endproperty
  a_lo: assert property (p_lo) else $error("flag kept after low read");
  property p_chan;
    sc1_wr |=> channel_select == $past(reg_wdata[4:0]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel not taken");
  property p_map;
    temp_sensor_en == (channel_select == CH_TEMP) && bandgap_en == (channel_select == CH_BANDGAP);
  endproperty
  a_map: assert property (p_map) else $error("internal source routing wrong");
  property p_irq;
    $rose(irq) |-> $past(sar_power_on);
  endproperty
  a_irq: assert property (p_irq) else $error("flag without conversion");
  property p_act;
    sample_en |-> sar_power_on && !mux_isolate;
  endproperty
  a_act: assert property (p_act) else $error("sampling while idle");
  c_done: cover property ($rose(irq));
  c_temp: cover property (sample_en && temp_sensor_en);
  c_lo: cover property (lo_rd && irq);
endmodule

bind sac_ctrl sac_ctrl_checker sac_ctrl_checker_inst (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .channel_select(channel_select), .mux_isolate(mux_isolate),
  .temp_sensor_en(temp_sensor_en), .bandgap_en(bandgap_en), .sar_power_on(sar_power_on),
  .sample_en(sample_en), .irq(irq)
);

// File: sac_pkg.sv
// Constants and types shared by the converter control block.
package sac_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [2:0] OFS_SC1 = 3'h0;
  localparam logic [2:0] OFS_SC2 = 3'h1;
  localparam logic [2:0] OFS_RES_HI = 3'h2;
  localparam logic [2:0] OFS_RES_LO = 3'h3;
  localparam logic [2:0] OFS_CMP_HI = 3'h4;
  localparam logic [2:0] OFS_CMP_LO = 3'h5;
  localparam logic [2:0] OFS_CFG = 3'h6;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned SC1_DONE = 7;
  localparam int unsigned SC1_IEN = 6;
  localparam int unsigned SC1_CONT = 5;
  localparam int unsigned SC2_ACT = 7;
  localparam int unsigned SC2_CMP_EN = 5;
  localparam int unsigned SC2_CMP_GE = 4;
  localparam int unsigned CFG_DIV_LSB = 5;
  localparam int unsigned CFG_LONG = 4;
  localparam int unsigned CFG_MODE_LSB = 2;
  localparam int unsigned CFG_SRC_LSB = 0;

  // ****************************************
  // Channel codes and reset values
  // ****************************************
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam logic [4:0] CH_TEMP = 5'h1a;
  localparam logic [4:0] CH_BANDGAP = 5'h1b;
  localparam logic [4:0] CH_RST = 5'h1f;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [9:0] CMP_RST = 10'h000;
  localparam logic [9:0] RES_RST = 10'h000;

  // ****************************************
  // Converter shape and timing
  // ****************************************
  localparam int unsigned RES_W = 10;
  localparam int unsigned DIV_CNT_W = 3;
  localparam logic [1:0] MODE_8BIT = 2'h0;
  localparam logic [4:0] SHORT_SAMPLE_TICKS = 5'h03;
  localparam logic [4:0] LONG_SAMPLE_TICKS = 5'h17;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SAC_SRC_BUS = 2'h0,
    SAC_SRC_HALF = 2'h1,
    SAC_SRC_ALT = 2'h2,
    SAC_SRC_ASYNC = 2'h3
  } sac_src_t;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'h0,
    SAC_SAMPLE = 2'h1,
    SAC_CONVERT = 2'h3,
    SAC_DONE = 2'h2
  } sac_state_t;

endpackage

// File: tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module tb;
  import sac_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [2:0] src_cnt = 3'h0;
  logic deep_stop_mode = 1'b0;
  logic cmp_above, mux_isolate, temp_sensor_en, bandgap_en, sar_power_on, sample_en, irq;
  logic [4:0] channel_select;
  logic [RES_W-1:0] dac_code;
  logic [RES_W-1:0] level = '0;
  logic [DATA_W-1:0] sc2_now = 8'h00;
  logic rd_seen = 1'b0;
  logic [DATA_W-1:0] exp_q[$];
  int bad_count = 0;
  int checks_done = 0;
  // ****************************************
  // Clocks, design and front end
  // ****************************************
  always #2.5 clk = ~clk;
  always @(posedge clk) src_cnt <= src_cnt + 3'h1;
  sac_ctrl sac_ctrl_inst (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_async_conv_clock(src_cnt[2]),
    .external_reference_clock(src_cnt[1]), .deep_stop_mode(deep_stop_mode),
    .cmp_above(cmp_above), .channel_select(channel_select), .mux_isolate(mux_isolate),
    .temp_sensor_en(temp_sensor_en), .bandgap_en(bandgap_en), .sar_power_on(sar_power_on),
    .sample_en(sample_en), .dac_code(dac_code), .irq(irq)
  );
  sac_afe_model sac_afe_model_inst (
    .clk(clk), .level(level), .sample_en(sample_en), .sar_power_on(sar_power_on),
    .dac_code(dac_code), .cmp_above(cmp_above)
  );
  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Each access leaves one idle cycle so no strobe is driven twice in one step.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 5000 && irq !== 1'b1; i++) begin
      @(posedge clk);
    end
    if (irq !== 1'b1) begin
      bad_count++;
      $display("MISMATCH irq expected 1 seen %b", irq);
      report_and_stop();
    end
  endtask
  task automatic convert(input logic [7:0] cfg, input logic [4:0] ch, input logic [9:0] lv);
    logic [9:0] r;
    r = (cfg[3:2] == MODE_8BIT) ? {2'h0, lv[9:2]} : lv;
    level <= lv;
    wr(OFS_CFG, cfg);
    wr(OFS_SC1, {3'h2, ch});
    wait_irq();
    rd(OFS_SC1, {3'h6, ch});
    rd(OFS_SC2, sc2_now);
    rd(OFS_CFG, cfg);
    rd(OFS_RES_HI, {6'h00, r[9:8]});
    rd(OFS_RES_LO, r[7:0]);
    cmp("irq", 10'h000, {9'h000, irq});
  endtask
  always @(posedge clk) begin
    rd_seen <= reg_rd;
    if (rd_seen) begin
      cmp("reg_rdata", {2'h0, exp_q.pop_front()}, {2'h0, reg_rdata});
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("MISMATCH run_length expected done seen hang");
    report_and_stop();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int s;
    logic [7:0] cfg;
    void'($urandom(84));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(OFS_SC1, {3'h0, CH_RST});
    for (s = 1; s < 8; s++) begin
      rd(3'(s), 8'h00);
    end
    cmp("mux_isolate", 10'h001, {9'h000, mux_isolate});
    for (s = 0; s < 4; s++) begin
      cfg = {1'b0, 2'($urandom_range(3)), 1'b0, 2'(s), 2'(s)};
      convert(cfg, 5'($urandom_range(7)), 10'($urandom));
    end
    // Long sample, bandgap before temperature, from the local clock.
    convert(8'h77, CH_BANDGAP, 10'h2e1);
    cmp("bandgap_en", 10'h001, {9'h000, bandgap_en});
    convert(8'h77, CH_TEMP, 10'h1d3);
    cmp("temp_sensor_en", 10'h001, {9'h000, temp_sensor_en});
    // Only the local clock is used in deep stop, with the regulator kept on.
    deep_stop_mode <= 1'b1;
    convert(8'h17, 5'h05, 10'h3ff);
    deep_stop_mode <= 1'b0;
    sc2_now = 8'h20;
    wr(OFS_SC2, sc2_now);
    wr(OFS_CMP_HI, 8'h03);
    wr(OFS_CMP_LO, 8'hff);
    convert(8'h04, 5'h02, 10'h155);
    sc2_now = 8'h30;
    wr(OFS_SC2, sc2_now);
    level <= 10'h0aa;
    wr(OFS_SC1, 8'h42);
    repeat (40) @(posedge clk);
    rd(OFS_SC1, 8'h42);
    rd(OFS_SC2, sc2_now);
    rd(OFS_RES_LO, 8'h55);
    sc2_now = 8'h00;
    wr(OFS_SC2, sc2_now);
    level <= 10'h2c3;
    wr(OFS_SC1, 8'h41);
    repeat (4) @(posedge clk);
    convert(8'h04, 5'h01, 10'h13c);
    wr(OFS_SC1, 8'h63);
    wait_irq();
    rd(OFS_SC2, 8'h80);
    rd(OFS_RES_LO, 8'h3c);
    wait_irq();
    wr(OFS_SC1, {3'h0, CH_OFF});
    repeat (40) @(posedge clk);
    rd(OFS_SC1, {3'h0, CH_OFF});
    rd(OFS_SC2, 8'h00);
    cmp("sar_power_on", 10'h000, {9'h000, sar_power_on});
    report_and_stop();
  end
endmodule
